// ===== pkg/stxp_pkg.sv
// stxp_pkg: shared constants and carrier types of the serial transmit path
package stxp_pkg;

    // character and word geometry
    localparam int CHAR_W = 10;
    localparam int MAX_CH = 4;
    localparam int WORD_W = CHAR_W * MAX_CH;

    // register byte addresses
    localparam logic [4:0] ADR_CTRL = 5'h00;
    localparam logic [4:0] ADR_COMMA = 5'h04;
    localparam logic [4:0] ADR_STATUS = 5'h08;
    localparam logic [4:0] ADR_MASK = 5'h0C;
    localparam logic [4:0] ADR_INFO = 5'h10;

    // control register fields
    localparam int CB_ENC_BYP = 0;
    localparam int CB_FIFO_BYP = 1;
    localparam int CB_WIDE10 = 2;
    localparam int CB_NCH_LO = 3;
    localparam int CB_LOOP_LO = 5;
    localparam logic [6:0] CTRL_RST = 7'h08;   // two characters, encoder and fifo on
    localparam logic [9:0] COMMA_RST = 10'h0FA; // comma sequence 0011111010

    // character count codes
    localparam logic [1:0] NCH_1 = 2'h0;
    localparam logic [1:0] NCH_2 = 2'h1;

    // loopback modes
    localparam logic [1:0] LOOP_OFF = 2'h0;
    localparam logic [1:0] LOOP_SER = 2'h1;
    localparam logic [1:0] LOOP_PAR = 2'h2;

    // status bit positions
    localparam int SB_OVF = 0;
    localparam int SB_UNF = 1;
    localparam int SB_KERR = 2;
    localparam int SB_COMMA = 3;
    localparam int NSTS = 4;

    // line rate and clock recovery constants
    localparam int REF_MUL = 20;
    localparam int REC_DIV = 20;
    localparam int LOSS_BITS = 64;

    // 8b/10b sub-block tables, negative disparity form, abcdei and fghj
    localparam logic [5:0] ENC6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] ENC4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [3:0] ENC4_ALT7 = 4'h7;
    localparam logic [5:0] ENC6_K28 = 6'h0F;
    localparam logic [4:0] X_K28 = 5'h1C;
    localparam logic [4:0] X_D07 = 5'h07;
    localparam logic [2:0] Y_ALT = 3'h7;
    localparam logic [2:0] Y_D3 = 3'h3;

    // register port request
    typedef struct packed {
        logic [4:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } stxp_bus_t;

    // one user word of up to four characters, bit 8 is the control qualifier
    typedef struct packed {
        logic [MAX_CH-1:0][CHAR_W-1:0] ch;
    } stxp_word_t;

endpackage

// ===== hw/stxp_top.sv
// stxp_top: serial transmit path with encoder, fifo, serializer and clock recovery
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module stxp_top #(
    parameter int NCH = stxp_pkg::MAX_CH,
    parameter int DEPTH = 4,
    parameter int PERW = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire stxp_pkg::stxp_bus_t i_bus,
    output logic [31:0] o_rd_data,
    // user transmit words
    input wire logic i_tx_valid,
    input wire stxp_pkg::stxp_word_t i_tx_word,
    output logic [NCH-1:0] o_tx_ctrl_code_error,
    output logic o_fifo_overflow,
    output logic o_fifo_underflow,
    // link pins
    input wire logic i_ref_clock_in,
    input wire logic i_serial_in,
    output logic o_serial_out_pos,
    output logic o_serial_out_neg,
    output logic o_rx_recovered_clock,
    output logic o_cdr_data_lock,
    output logic o_rx_comma,
    // interrupt
    output logic o_irq
);

    localparam int AW = $clog2(DEPTH);
    localparam int WW = NCH * stxp_pkg::CHAR_W;
    localparam int CW = $clog2(WW + 1);

    ////////////////////////////////////////////////////////////////////////
    // 8b/10b encoder: returns {error, running disparity out, code}
    function automatic logic [11:0] enc_char(input logic [7:0] b, input logic k,
                                             input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic m;
        logic ok;
        logic alt;
        logic [4:0] x;
        logic [2:0] y;
        x = b[4:0];
        y = b[7:5];
        ok = !k || x == stxp_pkg::X_K28 || (y == stxp_pkg::Y_ALT &&
             (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));
        s6 = (k && x == stxp_pkg::X_K28) ? stxp_pkg::ENC6_K28 : stxp_pkg::ENC6[x];
        if (rd && ($countones(s6) != 3 || x == stxp_pkg::X_D07)) begin
            s6 = ~s6;
        end
        m = rd ^ ($countones(s6) != 3);
        alt = y == stxp_pkg::Y_ALT && (k || (!m && (x == 5'h11 || x == 5'h12 ||
              x == 5'h14)) || (m && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        s4 = alt ? stxp_pkg::ENC4_ALT7 : stxp_pkg::ENC4[y];
        if ((m && ($countones(s4) != 2 || y == stxp_pkg::Y_D3)) ||
            (k && !m && $countones(s4) == 2 && y != stxp_pkg::Y_D3)) begin
            s4 = ~s4;
        end
        return {!ok, m ^ ($countones(s4) != 2), s6, s4};
    endfunction

    // number of characters selected by the count code
    function automatic int unsigned n_chars(input logic [1:0] code);
        return (code == stxp_pkg::NCH_1) ? 1 : (code == stxp_pkg::NCH_2) ? 2 : 4;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [6:0] ctrl_ff;
    logic [9:0] comma_ff;
    logic [stxp_pkg::NSTS-1:0] sts_ff;
    logic [stxp_pkg::NSTS-1:0] mask_ff;
    logic [stxp_pkg::NSTS-1:0] sts_set;
    logic [31:0] rd_data_ff;
    logic irq_ff;
    logic enc_byp;
    logic fifo_byp;
    logic wide10;
    logic [1:0] loop_mode;
    int unsigned nch;

    assign enc_byp = ctrl_ff[stxp_pkg::CB_ENC_BYP];
    assign fifo_byp = ctrl_ff[stxp_pkg::CB_FIFO_BYP];
    assign wide10 = ctrl_ff[stxp_pkg::CB_WIDE10];
    assign loop_mode = ctrl_ff[stxp_pkg::CB_LOOP_LO +: 2];
    assign nch = n_chars(ctrl_ff[stxp_pkg::CB_NCH_LO +: 2]);

    // control, comma pattern and mask writes
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ctrl_ff <= stxp_pkg::CTRL_RST;
            comma_ff <= stxp_pkg::COMMA_RST;
            mask_ff <= '0;
        end else if (i_bus.wr) begin
            if (i_bus.addr == stxp_pkg::ADR_CTRL) ctrl_ff <= i_bus.wdata[6:0];
            if (i_bus.addr == stxp_pkg::ADR_COMMA) comma_ff <= i_bus.wdata[9:0];
            if (i_bus.addr == stxp_pkg::ADR_MASK) mask_ff <= i_bus.wdata[stxp_pkg::NSTS-1:0];
        end
    end

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sts_ff <= '0;
        end else if (i_bus.wr && i_bus.addr == stxp_pkg::ADR_STATUS) begin
            sts_ff <= (sts_ff & ~i_bus.wdata[stxp_pkg::NSTS-1:0]) | sts_set;
        end else begin
            sts_ff <= sts_ff | sts_set;
        end
    end

    // interrupt level
    always_ff @(posedge i_clk) begin
        if (!i_rstn) irq_ff <= 1'b0;
        else irq_ff <= |(sts_ff & mask_ff);
    end

    ////////////////////////////////////////////////////////////////////////
    // encoder stage
    logic [WW-1:0] enc_word_ff;
    logic enc_vld_ff;
    logic rd_ff;
    logic [NCH-1:0] kerr_ff;
    logic [WW-1:0] nxt_enc_word;
    logic nxt_rd;
    logic [NCH-1:0] nxt_kerr;

    // encode used characters in order, disparity chained across them
    always_comb begin
        logic [11:0] r;
        logic [9:0] c;
        r = '0;
        c = '0;
        nxt_rd = rd_ff;
        nxt_kerr = '0;
        nxt_enc_word = '0;
        for (int i = 0; i < NCH; i++) begin
            c = i_tx_word.ch[i];
            if (i < nch) begin
                if (enc_byp) begin
                    nxt_enc_word[i*10 +: 10] = wide10 ? c : {2'h0, c[7:0]};
                end else begin
                    r = enc_char(c[7:0], c[8], nxt_rd);
                    nxt_enc_word[i*10 +: 10] = r[9:0];
                    nxt_rd = r[10];
                    nxt_kerr[i] = r[11] && !wide10;
                end
            end
        end
    end

    // register encoded word and error flags
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            enc_word_ff <= '0;
            enc_vld_ff <= 1'b0;
            rd_ff <= 1'b0;
            kerr_ff <= '0;
        end else begin
            enc_vld_ff <= i_tx_valid;
            kerr_ff <= i_tx_valid ? nxt_kerr : '0;
            if (i_tx_valid) begin
                enc_word_ff <= nxt_enc_word;
                rd_ff <= nxt_rd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link input synchronisers and reference edge finder
    logic [2:0] ref_sync_ff;
    logic [2:0] rxp_sync_ff;
    logic ref_rise;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ref_sync_ff <= '0;
            rxp_sync_ff <= '0;
        end else begin
            ref_sync_ff <= {ref_sync_ff[1:0], i_ref_clock_in};
            rxp_sync_ff <= {rxp_sync_ff[1:0], i_serial_in};
        end
    end
    assign ref_rise = ref_sync_ff[1] && !ref_sync_ff[2];

    ////////////////////////////////////////////////////////////////////////
    // transmit fifo, written per user word, read per reference edge
    logic [WW-1:0] fifo_mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic fifo_full;
    logic fifo_empty;
    logic push;
    logic pop;
    logic ovf_ff;
    logic unf_ff;
    logic [WW-1:0] byp_word_ff;
    logic byp_vld_ff;

    assign fifo_empty = wr_ptr_ff == rd_ptr_ff;
    assign fifo_full = wr_ptr_ff == {~rd_ptr_ff[AW], rd_ptr_ff[AW-1:0]};
    assign push = enc_vld_ff && !fifo_byp && !fifo_full;
    assign pop = ref_rise && !fifo_byp && !fifo_empty;

    // storage and pointers
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                fifo_mem_ff[wr_ptr_ff[AW-1:0]] <= enc_word_ff;
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

    // fifo bypass holding word, refreshed by every user word
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            byp_word_ff <= '0;
            byp_vld_ff <= 1'b0;
        end else if (enc_vld_ff && fifo_byp) begin
            byp_word_ff <= enc_word_ff;
            byp_vld_ff <= 1'b1;
        end else if (ref_rise) begin
            byp_vld_ff <= 1'b0;
        end
    end

    // overflow and underflow, only seen when rates are not locked
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ovf_ff <= 1'b0;
            unf_ff <= 1'b0;
        end else begin
            ovf_ff <= enc_vld_ff && !fifo_byp && fifo_full;
            unf_ff <= ref_rise && (fifo_byp ? !byp_vld_ff : fifo_empty);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit rate: twenty bits per measured reference period
    logic [PERW-1:0] per_cnt_ff;
    logic [PERW-1:0] per_ff;
    logic [PERW+5:0] acc_ff;
    logic [PERW+5:0] acc_sum;
    logic bit_en;

    assign acc_sum = acc_ff + (PERW+6)'(stxp_pkg::REF_MUL);
    assign bit_en = per_ff != '0 && acc_sum >= {6'h00, per_ff};

    // period measurement and bit phase accumulator
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            per_cnt_ff <= '0;
            per_ff <= '0;
            acc_ff <= '0;
        end else if (ref_rise) begin
            per_ff <= per_cnt_ff + 1'b1;
            per_cnt_ff <= '0;
            acc_ff <= '0;
        end else begin
            if (per_cnt_ff != '1) per_cnt_ff <= per_cnt_ff + 1'b1;
            acc_ff <= bit_en ? acc_sum - {6'h00, per_ff} : acc_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serializer: load on reference edge, first character first, msb first
    logic [WW-1:0] ser_sh_ff;
    logic [CW-1:0] ser_cnt_ff;
    logic [WW-1:0] ld_src;
    logic [WW-1:0] ld_word;
    logic ld_vld;
    logic ser_bit;

    assign ld_src = fifo_byp ? byp_word_ff : fifo_mem_ff[rd_ptr_ff[AW-1:0]];
    assign ld_vld = fifo_byp ? byp_vld_ff : !fifo_empty;
    assign ser_bit = ser_sh_ff[WW-1];
    always_comb begin
        ld_word = '0;
        for (int i = 0; i < NCH; i++) begin
            ld_word[WW-1-i*10 -: 10] = ld_src[i*10 +: 10];
        end
    end

    // shift register and remaining bit count
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ser_sh_ff <= '0;
            ser_cnt_ff <= '0;
        end else if (ref_rise) begin
            ser_sh_ff <= ld_vld ? ld_word : '0;
            ser_cnt_ff <= ld_vld ? CW'(nch * stxp_pkg::CHAR_W) : '0;
        end else if (bit_en && ser_cnt_ff != '0) begin
            ser_sh_ff <= {ser_sh_ff[WW-2:0], 1'b0};
            ser_cnt_ff <= ser_cnt_ff - 1'b1;
        end
    end

    // differential output pair
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_serial_out_pos <= 1'b0;
            o_serial_out_neg <= 1'b1;
        end else if (bit_en && ser_cnt_ff != '0) begin
            o_serial_out_pos <= ser_bit;
            o_serial_out_neg <= !ser_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive side: loopback select, clock recovery, comma detection
    logic rx_bit;
    logic rx_prev_ff;
    logic rx_edge;
    logic [7:0] silent_ff;
    logic lock_ff;
    logic [4:0] div_ff;
    logic rec_clk_ff;
    logic [9:0] rx_sh_ff;
    logic comma_ff_evt;
    logic par_hit;

    assign rx_bit = (loop_mode == stxp_pkg::LOOP_SER) ? o_serial_out_pos
                                                       : rxp_sync_ff[1];
    assign rx_edge = rx_bit != rx_prev_ff;

    // data presence: transitions seen within the loss window
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_prev_ff <= 1'b0;
            silent_ff <= 8'(stxp_pkg::LOSS_BITS);
            lock_ff <= 1'b0;
        end else begin
            rx_prev_ff <= rx_bit;
            if (rx_edge) silent_ff <= '0;
            else if (bit_en && silent_ff != 8'(stxp_pkg::LOSS_BITS)) silent_ff <= silent_ff + 1'b1;
            lock_ff <= silent_ff != 8'(stxp_pkg::LOSS_BITS);
        end
    end

    // divide received bit rate by twenty, phase taken on acquisition
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            div_ff <= '0;
        end else if (rx_edge && !lock_ff) begin
            div_ff <= '0;
        end else if (bit_en) begin
            div_ff <= (div_ff == 5'(stxp_pkg::REC_DIV - 1)) ? '0 : div_ff + 1'b1;
        end
    end

    // recovered clock, reference when no data is present
    always_ff @(posedge i_clk) begin
        if (!i_rstn) rec_clk_ff <= 1'b0;
        else rec_clk_ff <= lock_ff ? div_ff < 5'(stxp_pkg::REC_DIV / 2)
                                   : ref_sync_ff[1];
    end

    // parallel loopback compares loaded characters against the pattern
    always_comb begin
        par_hit = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (i < nch && ld_src[i*10 +: 10] == comma_ff) par_hit = 1'b1;
        end
    end

    // comma search over the received bit stream, or over the loaded characters in parallel loopback
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_sh_ff <= '0;
            comma_ff_evt <= 1'b0;
        end else begin
            if (bit_en) rx_sh_ff <= {rx_sh_ff[8:0], rx_bit};
            if (loop_mode == stxp_pkg::LOOP_PAR) begin
                comma_ff_evt <= ref_rise && ld_vld && par_hit;
            end else begin
                comma_ff_evt <= bit_en && {rx_sh_ff[8:0], rx_bit} == comma_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status events and read port
    always_comb begin
        sts_set = '0;
        sts_set[stxp_pkg::SB_OVF] = ovf_ff;
        sts_set[stxp_pkg::SB_UNF] = unf_ff;
        sts_set[stxp_pkg::SB_KERR] = |kerr_ff;
        sts_set[stxp_pkg::SB_COMMA] = comma_ff_evt;
    end

    // read data stand for one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !i_bus.rd) begin
            rd_data_ff <= '0;
        end else begin
            case (i_bus.addr)
                stxp_pkg::ADR_CTRL: rd_data_ff <= {25'h0, ctrl_ff};
                stxp_pkg::ADR_COMMA: rd_data_ff <= {22'h0, comma_ff};
                stxp_pkg::ADR_STATUS: rd_data_ff <= {28'h0, sts_ff};
                stxp_pkg::ADR_MASK: rd_data_ff <= {28'h0, mask_ff};
                stxp_pkg::ADR_INFO: rd_data_ff <= {27'h0, rd_ff, lock_ff,
                                                   wr_ptr_ff - rd_ptr_ff};
                default: rd_data_ff <= '0;
            endcase
        end
    end

    // output drives
    assign o_rd_data = rd_data_ff;
    assign o_irq = irq_ff;
    assign o_tx_ctrl_code_error = kerr_ff;
    assign o_fifo_overflow = ovf_ff;
    assign o_fifo_underflow = unf_ff;
    assign o_rx_recovered_clock = rec_clk_ff;
    assign o_cdr_data_lock = lock_ff;
    assign o_rx_comma = comma_ff_evt;

endmodule

// ===== testbench/stxp_user_model.sv
// stxp_user_model: user logic that sends one word per reference period
`timescale 1ns/1ps
module stxp_user_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // pacing and content
    input wire logic i_en,
    input wire logic i_ref_clock_in,
    input wire stxp_pkg::stxp_word_t i_word,
    // user word stream
    output logic o_valid,
    output stxp_pkg::stxp_word_t o_word
);
    logic [1:0] ref_ff;
    logic nxt_valid;

    // push on each reference rise so the write side stays frequency locked
    assign nxt_valid = i_en && ref_ff[0] && !ref_ff[1];
    // the word is inverted every cycle outside valid so stale data never holds steady
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ref_ff <= 2'h0;
            o_valid <= 1'b0;
            o_word <= '0;
        end else begin
            ref_ff <= {ref_ff[0], i_ref_clock_in};
            o_valid <= nxt_valid;
            o_word <= nxt_valid ? i_word : ~o_word;
        end
    end
endmodule

// ===== testbench/stxp_top_sva.sv
// stxp_top_sva: port level assertions of the serial transmit path
`timescale 1ns/1ps
module stxp_top_sva #(
    parameter int NCH = 4
) (
    // clock, reset and register port
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire stxp_pkg::stxp_bus_t i_bus,
    input wire logic [31:0] o_rd_data,
    // user words and fifo status
    input wire logic i_tx_valid,
    input wire stxp_pkg::stxp_word_t i_tx_word,
    input wire logic [NCH-1:0] o_tx_ctrl_code_error,
    input wire logic o_fifo_overflow,
    input wire logic o_fifo_underflow,
    // link pins
    input wire logic i_ref_clock_in,
    input wire logic i_serial_in,
    input wire logic o_serial_out_pos,
    input wire logic o_serial_out_neg,
    input wire logic o_rx_recovered_clock,
    input wire logic o_cdr_data_lock
);
    logic [5:0] ref_hist_ff;
    logic ser_ff;
    logic [6:0] quiet_ff;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // reference history and cycles since the receive pin last moved
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ref_hist_ff <= 6'h00;
            ser_ff <= 1'b0;
            quiet_ff <= 7'h00;
        end else begin
            ref_hist_ff <= {ref_hist_ff[4:0], i_ref_clock_in};
            ser_ff <= i_serial_in;
            quiet_ff <= (ser_ff != i_serial_in) ? 7'h00 : quiet_ff + 7'(quiet_ff != 7'h7F);
        end
    end

    ////////////////////////////////////////////////////////////////
    sequence s_rd_done;
        i_bus.rd ##1 !i_bus.rd;
    endsequence

    a_rd_data_stands: assert property (s_rd_done |=> o_rd_data == 32'h0)
        else $error("read data not cleared after its cycle");
    a_diff_pair: assert property (o_serial_out_neg != o_serial_out_pos)
        else $error("serial pair not complementary");
    a_kerr_cause: assert property (o_tx_ctrl_code_error[0] |->
        $past(i_tx_valid) && $past(i_tx_word.ch[0][8]))
        else $error("code error without qualified word");
    a_kerr_last_char: assert property (o_tx_ctrl_code_error[NCH-1] |->
        $past(i_tx_valid) && $past(i_tx_word.ch[NCH-1][8]))
        else $error("last char code error without qualified word");
    a_ovf_cause: assert property (o_fifo_overflow |-> $past(i_tx_valid, 2))
        else $error("overflow without a word two cycles before");
    a_unf_ref_rise: assert property (o_fifo_underflow |->
        |(ref_hist_ff[4:0] & ~ref_hist_ff[5:1]))
        else $error("underflow without a reference rise");
    a_unf_single: assert property (o_fifo_underflow |=> !o_fifo_underflow)
        else $error("underflow longer than one cycle");
    a_lock_loss: assert property ($fell(o_cdr_data_lock) |-> quiet_ff >= 7'd60)
        else $error("lock lost while receive pin active");
    a_recclk_ref: assert property ((!o_cdr_data_lock) [*6] |->
        o_rx_recovered_clock inside {$past(i_ref_clock_in, 2), $past(i_ref_clock_in, 3),
        $past(i_ref_clock_in, 4)})
        else $error("recovered clock not following reference");
endmodule

bind stxp_top stxp_top_sva #(.NCH(NCH)) sva_u (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_bus(i_bus), .o_rd_data(o_rd_data), .i_tx_valid(i_tx_valid), .i_tx_word(i_tx_word),
    .o_tx_ctrl_code_error(o_tx_ctrl_code_error), .o_fifo_overflow(o_fifo_overflow),
    .o_fifo_underflow(o_fifo_underflow), .i_ref_clock_in(i_ref_clock_in),
    .i_serial_in(i_serial_in), .o_serial_out_pos(o_serial_out_pos),
    .o_serial_out_neg(o_serial_out_neg), .o_rx_recovered_clock(o_rx_recovered_clock),
    .o_cdr_data_lock(o_cdr_data_lock));

// ===== testbench/stxp_top_tb.sv
// stxp_top_tb: register driven test of the serial transmit path
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module stxp_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    stxp_pkg::stxp_bus_t bus = '0;
    stxp_pkg::stxp_word_t tb_word = '0;
    stxp_pkg::stxp_word_t p_word;
    logic tb_valid = 1'b0;
    logic p_en = 1'b0;
    logic refc = 1'b0;
    logic ref_en = 1'b0;
    logic ser_in = 1'b0;
    logic p_valid, ovf, unf, pos, neg, rec, lock, comma, irq;
    logic [3:0] kerr;
    logic [31:0] rd_data, d;
    int ref_half = 160;
    int errors = 0;
    int cmp_count = 0;
    logic [7:0] kchar [16] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC, 8'hFC,
        8'hF7, 8'hFB, 8'hFD, 8'hFE, 8'h00, 8'h1D, 8'hBD, 8'hFF};

    // system clock and a link clock offset from its edges
    always #20 clk = ~clk;
    initial begin
        #7;
        forever begin
            #(ref_half);
            refc = ref_en & ~refc;
        end
    end

    // design and user side partner
    stxp_top dut_u (.i_clk(clk), .i_rstn(rstn), .i_bus(bus), .o_rd_data(rd_data),
        .i_tx_valid(p_en ? p_valid : tb_valid), .i_tx_word(p_en ? p_word : tb_word),
        .o_tx_ctrl_code_error(kerr), .o_fifo_overflow(ovf), .o_fifo_underflow(unf),
        .i_ref_clock_in(refc), .i_serial_in(ser_in), .o_serial_out_pos(pos),
        .o_serial_out_neg(neg), .o_rx_recovered_clock(rec), .o_cdr_data_lock(lock),
        .o_rx_comma(comma), .o_irq(irq));
    stxp_user_model user_u (.i_clk(clk), .i_rstn(rstn), .i_en(p_en), .i_ref_clock_in(refc),
        .i_word(tb_word), .o_valid(p_valid), .o_word(p_word));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [4:0] a);
        bus <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 32'h0};
        @(posedge clk);
        bus <= '0;
        #1;
        d = rd_data;
        @(posedge clk);
    endtask
    task automatic send(input logic [9:0] c);
        tb_word <= {4{c}};
        tb_valid <= 1'b1;
        @(posedge clk);
        tb_valid <= 1'b0;
    endtask
    task automatic wait_lock(input logic v);
        int n;
        n = 0;
        while (lock !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK("lock", v, lock)
        if (n == 400) close_out();
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(stxp_pkg::ADR_CTRL);
        `CHK("ctrl", {25'h0, stxp_pkg::CTRL_RST}, d)
        rd(stxp_pkg::ADR_COMMA);
        `CHK("comma", {22'h0, stxp_pkg::COMMA_RST}, d)
        rd(stxp_pkg::ADR_MASK);
        `CHK("mask", 32'h0, d)
        wr(5'h14, 32'hFFFF_FFFF);
        rd(5'h14);
        `CHK("unmapped", 32'h0, d)
        wr(stxp_pkg::ADR_CTRL, 32'h10);
        rd(stxp_pkg::ADR_CTRL);
        `CHK("ctrl", 32'h10, d)
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            send({2'b01, kchar[i]});
            #1;
            `CHK("kerr", {4{i >= 12}}, kerr)
            @(posedge clk);
        end
        send(10'h0FF);
        #1;
        `CHK("kerr data", 4'h0, kerr)
        @(posedge clk);
        rd(stxp_pkg::ADR_STATUS);
        `CHK("kerr status", 1'b1, d[stxp_pkg::SB_KERR])
        wr(stxp_pkg::ADR_MASK, 32'h4);
        cyc(2);
        `CHK("irq set", 1'b1, irq)
        wr(stxp_pkg::ADR_STATUS, 32'h4);
        cyc(2);
        `CHK("irq clear", 1'b0, irq)
        wr(stxp_pkg::ADR_CTRL, 32'h15);
        send(10'h100);
        #1;
        `CHK("kerr bypass", 4'h0, kerr)
        @(posedge clk);
        $display("test encoder done");
        wr(stxp_pkg::ADR_CTRL, 32'h08);
        ref_en = 1'b1;
        cyc(40);
        rd(stxp_pkg::ADR_STATUS);
        `CHK("underflow", 1'b1, d[stxp_pkg::SB_UNF])
        wr(stxp_pkg::ADR_STATUS, 32'hF);
        tb_valid <= 1'b1;
        cyc(8);
        tb_valid <= 1'b0;
        cyc(4);
        rd(stxp_pkg::ADR_STATUS);
        `CHK("overflow", 1'b1, d[stxp_pkg::SB_OVF])
        wr(stxp_pkg::ADR_MASK, 32'h1);
        cyc(2);
        `CHK("irq ovf", 1'b1, irq)
        wr(stxp_pkg::ADR_STATUS, 32'h1);
        cyc(2);
        `CHK("irq ovf clear", 1'b0, irq)
        $display("test fifo limits done");
        p_en <= 1'b1;
        cyc(80);
        wr(stxp_pkg::ADR_STATUS, 32'hF);
        cyc(160);
        rd(stxp_pkg::ADR_STATUS);
        `CHK("locked flow", 2'h0, d[1:0])
        p_en <= 1'b0;
        $display("test locked flow done");
        ref_en = 1'b0;
        cyc(5);
        ref_half = 520;
        ref_en = 1'b1;
        wr(stxp_pkg::ADR_COMMA, 32'h305);
        for (int m = 0; m < 3; m++) begin
            wr(stxp_pkg::ADR_CTRL, 32'(m) << 5);
            cyc(80);
            wr(stxp_pkg::ADR_STATUS, 32'hF);
            send(10'h1BC);
            cyc(60);
            send(10'h1BC);
            cyc(80);
            rd(stxp_pkg::ADR_STATUS);
            `CHK("comma", m != 0, d[stxp_pkg::SB_COMMA])
        end
        $display("test loopback done");
        wr(stxp_pkg::ADR_CTRL, 32'h08);
        for (int i = 0; i < 60; i++) begin
            ser_in <= ~ser_in;
            cyc(3);
        end
        wait_lock(1'b1);
        wait_lock(1'b0);
        $display("test recovery done");
        close_out();
    end
endmodule
